// File: logic/apr_pkg.sv
/*
  Constants, register map and carrier types of the auxiliary pin routing
  register bank. Assumes a byte-wide register space reached by an address,
  read and write strobes, and a page index held inside the bank itself.
*/
// Notes on behaviour
// - Polarity bit 0 means low or falling trigger; 1 means high or rising.
// - Keypad field picks P0, P2, P5 or P4.3-0 with P3.7-4.
// - Serial peripheral pins sit on P1/P5 when 0, on P4/P3 when 1.
// - Second UART on P7.0/P7.1 when high bit set, else low field picks pair.
// - Timer 0/1 pins on P3.4/P3.5 when clear, P5.5/P5.6 when set.
// - Bit 0 serves expanded RAM on chip; bit 1 disables on-chip expanded RAM.
// - Pointer select bit chooses first pointer at 0, second at 1.
// - Address goes out on P5, P6.7-2, P7.1-0 only when interface mode is 11.
// - Prescale bit selects clock divided by 12 at 0, undivided at 1.
// - Clock-out enables drive timer 0 and 1 clocks onto their pins.
// - Start and stop flags set by hardware, cleared by firmware writing zero.
// - Beeper field: 00 plain port, else slow oscillator over 64, 32 or 16.
// - Latch strobe high-active at 0, low-active at 1; on P4.6 or P4.7.
// - First two-wire port on P4.0/1, P6.0/1, P3.0/1 or P3.4/5.
// - Timer 2 pins on P1.0/P1.1 when clear, P3.6/P3.7 when set.
// - Counter array channels 2, 0, 4 pick pin, comparator or oscillator.
// - Comparator output enables drive results onto P7.2, P0.0 and P6.4.
// - Four serial auxiliary inputs on P4.0-3 when clear, P5.3-6 when set.
// - Fourth and third UARTs each move between two pin pairs by one bit.
// - Timer 3 routed by two bits starting P4.6/P7.2; timer 4 by one bit.
// - Two-bit fields pick the pin feeding each of four external interrupts.
// - Four-bit page index selects paged registers; upper bits read zero.
package apr_pkg;

  // ----------------------------------------------------------------------
  // Register addresses and pages
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ROUTE_ONE = 8'hA2;
  localparam logic [7:0] ADDR_TIMER_BUS = 8'hA3;
  localparam logic [7:0] ADDR_PAGED_A4  = 8'hA4;
  localparam logic [7:0] ADDR_PAGE_IDX  = 8'hAC;
  localparam logic [7:0] ADDR_PAGED_C1  = 8'hC1;
  localparam logic [3:0] PAGE_0         = 4'h0;
  localparam logic [3:0] PAGE_1         = 4'h1;
  localparam logic [3:0] PAGE_2         = 4'h2;
  localparam logic [3:0] PAGE_3         = 4'h3;
  localparam logic [3:0] PAGE_4         = 4'h4;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions and read masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_TIMER_BUS = 8'hCF;
  localparam logic [7:0] MASK_ARRAY     = 8'h3F;
  localparam logic [7:0] MASK_PAGE      = 8'h0F;
  localparam int         BIT_START_FLAG = 7;
  localparam int         BIT_STOP_FLAG  = 6;
  localparam logic [1:0] MODE_ADDR_OUT  = 2'b11;

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam int         PRESCALE_DIV   = 12;
  localparam logic [3:0] PRESCALE_LAST  = 4'(PRESCALE_DIV - 1);

  // ----------------------------------------------------------------------
  // Interrupt pin tables, each entry {port[2:0], bit[2:0]}
  // ----------------------------------------------------------------------
  localparam logic [5:0] IRQ_PIN [4][4] = '{
    '{6'o32, 6'o30, 6'o16, 6'o40},
    '{6'o33, 6'o31, 6'o17, 6'o41},
    '{6'o43, 6'o62, 6'o14, 6'o61},
    '{6'o42, 6'o63, 6'o15, 6'o60}
  };

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef logic [7:0][7:0] apr_port_t;

  typedef enum logic [9:0] {
    APR_NONE = 10'b0000000001,
    APR_R1   = 10'b0000000010,
    APR_R2   = 10'b0000000100,
    APR_R3   = 10'b0000001000,
    APR_R4   = 10'b0000010000,
    APR_R5   = 10'b0000100000,
    APR_R6   = 10'b0001000000,
    APR_R7   = 10'b0010000000,
    APR_PIDX = 10'b0100000000,
    APR_XCFG = 10'b1000000000
  } apr_reg_t;

  typedef struct packed {
    logic [1:0] keypad_route_sel;
    logic       spi_route_sel;
    logic [2:0] uart_b_route;
    logic       timer01_route_sel;
    logic [1:0] two_wire_route_sel;
    logic [1:0] two_wire_b_route_sel;
    logic       timer_c_route_sel;
    logic       serial_aux_in_route;
    logic       uart_d_route_sel;
    logic       uart_c_route_sel;
    logic [1:0] timer_d_route_sel;
    logic       timer_e_route_sel;
  } apr_route_t;

endpackage

// File: logic/apr_regs.sv
/*
  Auxiliary pin routing register bank with its pin overrides, interrupt
  pin selection, prescale ticks, beeper divider and array input muxes.
  Assumes all inputs are synchronous to sys_clk_i and that the slow
  oscillator arrives as a one-cycle enable pulse.
*/
`timescale 1ns/1ps
module apr_regs
  import apr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire apr_port_t  port_in_i,
  input  wire logic       wire_start_det_i,
  input  wire logic       wire_stop_det_i,
  input  wire logic       lfo_tick_i,
  input  wire logic       timer_a_clk_i,
  input  wire logic       timer_b_clk_i,
  input  wire logic [2:0] cmp_result_i,
  input  wire logic [2:0] array_b_pin_i,
  input  wire logic       ext_cycle_i,
  input  wire logic       ale_i,
  input  wire logic [15:0] ext_addr_i,
  input  wire logic [1:0] ext_mem_iface_mode_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            sfr_hit_o,
  output apr_port_t       pin_drv_o,
  output apr_port_t       pin_oe_n_o,
  output logic [7:0]      keypad_inputs_o,
  output logic [3:0]      irq_active_o,
  output logic [2:0]      array_b_ch_o,
  output logic            onchip_xram_en_o,
  output logic            pointer_select_o,
  output logic            timer_a_tick_o,
  output logic            timer_b_tick_o,
  output logic            wire_start_flag_o,
  output logic            wire_stop_flag_o,
  output logic [3:0]      page_index_o,
  output apr_route_t      route_o
);

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  logic [7:0] r1_q, r2_q, r3_q, r4_q, r5_q, r6_q, r7_q;
  logic [7:0] page_q, xl_q, xh_q;
  logic [3:0] div_q;
  logic [5:0] beep_q;
  apr_reg_t   wsel;

  function automatic apr_reg_t reg_decode(input logic [7:0] a,
                                          input logic [3:0] pg);
    reg_decode = APR_NONE;
    case (a)
      ADDR_ROUTE_ONE: reg_decode = APR_R1;
      ADDR_TIMER_BUS: reg_decode = APR_R2;
      ADDR_PAGE_IDX:  reg_decode = APR_PIDX;
      ADDR_PAGED_A4:
      begin
        case (pg)
          PAGE_0:  reg_decode = APR_R3;
          PAGE_1:  reg_decode = APR_R4;
          PAGE_2:  reg_decode = APR_R5;
          PAGE_3:  reg_decode = APR_R6;
          PAGE_4:  reg_decode = APR_R7;
          default: reg_decode = APR_NONE;
        endcase
      end
      ADDR_PAGED_C1:
      begin
        if (pg == PAGE_0 || pg == PAGE_1)
          reg_decode = APR_XCFG;
      end
      default: reg_decode = APR_NONE;
    endcase
  endfunction

  function automatic logic pin_at(input apr_port_t p, input logic [5:0] c);
    pin_at = p[c[5:3]][c[2:0]];
  endfunction

  assign wsel = reg_decode(sfr_addr_i, page_q[3:0]);

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      r1_q   <= REG_RESET;
      r2_q   <= REG_RESET;
      r4_q   <= REG_RESET;
      r5_q   <= REG_RESET;
      r6_q   <= REG_RESET;
      r7_q   <= REG_RESET;
      page_q <= REG_RESET;
      xl_q   <= REG_RESET;
      xh_q   <= REG_RESET;
    end
    else if (sfr_wr_i)
    begin
      case (wsel)
        APR_R1:   r1_q <= sfr_wdata_i;
        APR_R2:   r2_q <= sfr_wdata_i & MASK_TIMER_BUS;
        APR_R4:   r4_q <= sfr_wdata_i;
        APR_R5:   r5_q <= sfr_wdata_i;
        APR_R6:   r6_q <= sfr_wdata_i & MASK_ARRAY;
        APR_R7:   r7_q <= sfr_wdata_i;
        APR_PIDX: page_q <= sfr_wdata_i & MASK_PAGE;
        APR_XCFG:
        begin
          if (page_q[3:0] == PAGE_0)
            xl_q <= sfr_wdata_i;
          else
            xh_q <= sfr_wdata_i;
        end
        default:  r1_q <= r1_q;
      endcase
    end
  end

  // Paged register with hardware-set flags; a set in the same cycle as a
  // firmware clear wins. Writing one to a flag leaves it unchanged.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r3_q <= REG_RESET;
    else
    begin
      if (sfr_wr_i && wsel == APR_R3)
      begin
        r3_q[5:0] <= sfr_wdata_i[5:0];
        r3_q[BIT_START_FLAG] <= (r3_q[BIT_START_FLAG]
          & sfr_wdata_i[BIT_START_FLAG]) | wire_start_det_i;
        r3_q[BIT_STOP_FLAG] <= (r3_q[BIT_STOP_FLAG]
          & sfr_wdata_i[BIT_STOP_FLAG]) | wire_stop_det_i;
      end
      else
      begin
        if (wire_start_det_i)
          r3_q[BIT_START_FLAG] <= 1'b1;
        if (wire_stop_det_i)
          r3_q[BIT_STOP_FLAG] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  logic [7:0] rd_d;
  apr_reg_t   rsel;

  always_comb
  begin
    rsel = reg_decode(sfr_addr_i, page_q[3:0]);
    case (rsel)
      APR_R1:   rd_d = r1_q;
      APR_R2:   rd_d = r2_q;
      APR_R3:   rd_d = r3_q;
      APR_R4:   rd_d = r4_q;
      APR_R5:   rd_d = r5_q;
      APR_R6:   rd_d = r6_q;
      APR_R7:   rd_d = r7_q;
      APR_PIDX: rd_d = page_q;
      APR_XCFG: rd_d = (page_q[3:0] == PAGE_0) ? xl_q : xh_q;
      default:  rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o   <= 1'b0;
    end
    else if (sfr_rd_i)
    begin
      sfr_rdata_o <= rd_d;
      sfr_hit_o   <= (rsel != APR_NONE);
    end
    else
      sfr_hit_o   <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Prescale and beeper dividers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      div_q <= 4'h0;
    else if (div_q == PRESCALE_LAST)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      beep_q <= 6'h00;
    else if (lfo_tick_i)
      beep_q <= beep_q + 6'h01;
  end

  // ----------------------------------------------------------------------
  // Pin overrides, recomputed every cycle from the current routes
  // ----------------------------------------------------------------------
  apr_port_t drv_d;
  apr_port_t en_d;
  logic      beep_lvl;

  always_comb
  begin
    drv_d = '0;
    en_d  = '0;
    case (r3_q[5:4])
      2'b01:   beep_lvl = beep_q[5];
      2'b10:   beep_lvl = beep_q[4];
      2'b11:   beep_lvl = beep_q[3];
      default: beep_lvl = 1'b0;
    endcase
    if (r3_q[5:4] != 2'b00)
    begin
      drv_d[4][4] = beep_lvl;
      en_d[4][4]  = 1'b1;
    end
    if (r2_q[0])
    begin
      drv_d[r1_q[2] ? 5 : 3][r1_q[2] ? 5 : 4] = timer_a_clk_i;
      en_d[r1_q[2] ? 5 : 3][r1_q[2] ? 5 : 4]  = 1'b1;
    end
    if (r2_q[1])
    begin
      drv_d[r1_q[2] ? 5 : 3][r1_q[2] ? 6 : 5] = timer_b_clk_i;
      en_d[r1_q[2] ? 5 : 3][r1_q[2] ? 6 : 5]  = 1'b1;
    end
    if (r4_q[3])
    begin
      drv_d[7][2] = cmp_result_i[1];
      en_d[7][2]  = 1'b1;
    end
    if (r4_q[1])
    begin
      drv_d[0][0] = cmp_result_i[0];
      en_d[0][0]  = 1'b1;
    end
    if (r7_q[1])
    begin
      drv_d[6][4] = cmp_result_i[2];
      en_d[6][4]  = 1'b1;
    end
    if (ext_cycle_i)
    begin
      drv_d[4][r3_q[3] ? 7 : 6] = ale_i ^ r2_q[7];
      en_d[4][r3_q[3] ? 7 : 6]  = 1'b1;
    end
    if (r2_q[6] && ext_mem_iface_mode_i == MODE_ADDR_OUT && ext_cycle_i)
    begin
      drv_d[5]      = ext_addr_i[7:0];
      en_d[5]       = 8'hFF;
      drv_d[6][7:2] = ext_addr_i[15:10];
      en_d[6][7:2]  = 6'h3F;
      drv_d[7][1:0] = ext_addr_i[9:8];
      en_d[7][1:0]  = 2'h3;
    end
  end

  // Pins not named by the current routes are released on the next clock edge.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_drv_o  <= '0;
      pin_oe_n_o <= '1;
    end
    else
    begin
      pin_drv_o  <= drv_d;
      pin_oe_n_o <= ~en_d;
    end
  end

  // ----------------------------------------------------------------------
  // Input routing: keypad, interrupts, counter array channels
  // ----------------------------------------------------------------------
  logic [3:0] irq_pin;
  logic [7:0] irq_sel;

  assign irq_sel = {xh_q[7:4], xl_q[7:4]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_irq
      assign irq_pin[gi] = pin_at(port_in_i,
        IRQ_PIN[gi][irq_sel[2*gi+:2]]);
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      keypad_inputs_o <= 8'h00;
      irq_active_o    <= 4'h0;
      array_b_ch_o    <= 3'h0;
    end
    else
    begin
      case (r1_q[7:6])
        2'b00:   keypad_inputs_o <= port_in_i[0];
        2'b01:   keypad_inputs_o <= port_in_i[2];
        2'b10:   keypad_inputs_o <= port_in_i[5];
        default: keypad_inputs_o <= {port_in_i[4][3:0], port_in_i[3][7:4]};
      endcase
      irq_active_o[0] <= r_pol(1'b0) ? irq_pin[0] : ~irq_pin[0];
      irq_active_o[1] <= r_pol(1'b1) ? irq_pin[1] : ~irq_pin[1];
      irq_active_o[3:2] <= ~irq_pin[3:2];
      case (r4_q[5:4])
        2'b00:   array_b_ch_o[0] <= array_b_pin_i[0];
        2'b01:   array_b_ch_o[0] <= cmp_result_i[0];
        2'b11:   array_b_ch_o[0] <= lfo_tick_i;
        default: array_b_ch_o[0] <= 1'b0;
      endcase
      case (r4_q[7:6])
        2'b00:   array_b_ch_o[1] <= array_b_pin_i[1];
        2'b01:   array_b_ch_o[1] <= cmp_result_i[1];
        2'b11:   array_b_ch_o[1] <= cmp_result_i[0];
        default: array_b_ch_o[1] <= 1'b0;
      endcase
      array_b_ch_o[2] <= r6_q[3] ? cmp_result_i[2] : array_b_pin_i[2];
    end
  end

  // Polarity bits belong to a register outside this bank, so they are
  // kept here and written through bits 3:2 of the page-4 register.
  logic [1:0] pol_q;

  function automatic logic r_pol(input logic idx);
    r_pol = pol_q[idx];
  endfunction

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pol_q <= 2'b00;
    else if (sfr_wr_i && wsel == APR_R7)
      pol_q <= sfr_wdata_i[3:2];
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      onchip_xram_en_o  <= 1'b1;
      pointer_select_o  <= 1'b0;
      timer_a_tick_o    <= 1'b0;
      timer_b_tick_o    <= 1'b0;
      wire_start_flag_o <= 1'b0;
      wire_stop_flag_o  <= 1'b0;
      page_index_o      <= 4'h0;
      route_o           <= '0;
    end
    else
    begin
      onchip_xram_en_o  <= ~r1_q[1];
      pointer_select_o  <= r1_q[0];
      timer_a_tick_o    <= r2_q[2] | (div_q == PRESCALE_LAST);
      timer_b_tick_o    <= r2_q[3] | (div_q == PRESCALE_LAST);
      wire_start_flag_o <= r3_q[BIT_START_FLAG];
      wire_stop_flag_o  <= r3_q[BIT_STOP_FLAG];
      page_index_o      <= page_q[3:0];
      route_o.keypad_route_sel     <= r1_q[7:6];
      route_o.spi_route_sel        <= r1_q[5];
      route_o.uart_b_route         <= {r6_q[0], r1_q[4:3]};
      route_o.timer01_route_sel    <= r1_q[2];
      route_o.two_wire_route_sel   <= r3_q[2:1];
      route_o.two_wire_b_route_sel <= r6_q[5:4];
      route_o.timer_c_route_sel    <= r3_q[0];
      route_o.serial_aux_in_route  <= r5_q[7];
      route_o.uart_d_route_sel     <= r5_q[6];
      route_o.uart_c_route_sel     <= r5_q[5];
      route_o.timer_d_route_sel    <= r5_q[1:0];
      route_o.timer_e_route_sel    <= r5_q[2];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  start_flag_set_a: assert property (
    wire_start_det_i |=> r3_q[BIT_START_FLAG])
    else $error("start flag not set after detection");

  stop_flag_hold_a: assert property (
    r3_q[BIT_STOP_FLAG] && !(sfr_wr_i && wsel == APR_R3)
    |=> r3_q[BIT_STOP_FLAG])
    else $error("stop flag dropped without a clear");

  page_upper_zero_a: assert property (
    sfr_wr_i && wsel == APR_PIDX |=> page_q[7:4] == 4'h0
    && page_q[3:0] == $past(sfr_wdata_i[3:0]))
    else $error("page index write wrong");

  xram_enable_a: assert property (
    ##2 onchip_xram_en_o == !$past(r1_q[1], 1))
    else $error("on-chip expanded RAM enable wrong");

  pointer_sel_a: assert property (
    sfr_wr_i && wsel == APR_R1 |=> ##1
    pointer_select_o == $past(sfr_wdata_i[0], 2))
    else $error("pointer select not following write");

  prescale_gap_a: assert property (
    timer_a_tick_o && !r2_q[2] && $stable(r2_q[2])
    |=> (!timer_a_tick_o || $past(r2_q[2])) [*8])
    else $error("divided tick too frequent");

  beeper_off_a: assert property (
    r3_q[5:4] == 2'b00 && !(r2_q[0] | r2_q[1]) |=> pin_oe_n_o[4][4])
    else $error("beeper pin driven while off");

  addr_out_a: assert property (
    r2_q[6] && ext_mem_iface_mode_i == MODE_ADDR_OUT && ext_cycle_i
    |=> pin_oe_n_o[5] == 8'h00 && pin_drv_o[5] == $past(ext_addr_i[7:0]))
    else $error("address not driven on low port");

  addr_mode_a: assert property (
    ext_mem_iface_mode_i != MODE_ADDR_OUT && !r1_q[2]
    |=> pin_oe_n_o[5] == 8'hFF)
    else $error("address driven in wrong mode");

  keypad_route_a: assert property (
    r1_q[7:6] == 2'b01 |=> keypad_inputs_o == $past(port_in_i[2]))
    else $error("keypad route wrong");

  cmp_out_a: assert property (
    r4_q[3] |=> !pin_oe_n_o[7][2] && pin_drv_o[7][2] == $past(cmp_result_i[1]))
    else $error("comparator output not driven");

  irq_pol_a: assert property (
    1'b1 |=> irq_active_o[0] == ($past(pol_q[0]) ? $past(irq_pin[0])
                                                  : !$past(irq_pin[0])))
    else $error("interrupt polarity wrong");

  flag_seen_c: cover property (wire_start_det_i ##1 r3_q[BIT_START_FLAG]);
  addr_cycle_c: cover property (!pin_oe_n_o[5][0]);
  beeper_on_c: cover property (!pin_oe_n_o[4][4] && pin_drv_o[4][4]);
  page_change_c: cover property (page_index_o == PAGE_3);

endmodule

// File: tb/apr_regs_tb.sv
/*
  Self-checking bench of the auxiliary pin routing register bank.
  Assumes apr_pkg and apr_regs are compiled before it.
*/
`timescale 1ns/1ps
module apr_regs_tb
  import apr_pkg::*;
();
  logic        clk, nrst, wr, rd, st_det, sp_det, ta_clk, ecyc, rd_d;
  logic        hit, psel, xram_en, ta_tick;
  logic        sflag, pflag, tb_tick;
  logic [2:0]  cmpr, ach;
  logic [7:0]  addr, wdata, rdata, kpd, v, e;
  logic [5:0]  j;
  logic [15:0] eaddr;
  logic [1:0]  emode;
  logic [3:0]  irq, pidx;
  apr_port_t   pin_in, drv, oe_n;
  apr_route_t  route;
  logic [8:0]  exp_q[$];
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n;

  apr_regs i_apr_regs (
    .sys_clk_i(clk), .nrst_i(nrst), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .port_in_i(pin_in),
    .wire_start_det_i(st_det), .wire_stop_det_i(sp_det),
    .lfo_tick_i(1'b0), .timer_a_clk_i(ta_clk), .timer_b_clk_i(1'b0),
    .cmp_result_i(cmpr), .array_b_pin_i(3'h0), .ext_cycle_i(ecyc),
    .ale_i(1'b0), .ext_addr_i(eaddr), .ext_mem_iface_mode_i(emode),
    .sfr_rdata_o(rdata), .sfr_hit_o(hit), .pin_drv_o(drv),
    .pin_oe_n_o(oe_n), .keypad_inputs_o(kpd), .irq_active_o(irq),
    .array_b_ch_o(ach), .onchip_xram_en_o(xram_en),
    .pointer_select_o(psel), .timer_a_tick_o(ta_tick),
    .timer_b_tick_o(tb_tick), .wire_start_flag_o(sflag),
    .wire_stop_flag_o(pflag),
    .page_index_o(pidx), .route_o(route)
  );

  // ----------------------------------------------------------------
  // Clock, checking and bus tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_lv(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
    cmp_lv(64'(got), 64'(exp));
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [8:0] x);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    exp_q.push_back(x);
    @(negedge clk);
    rd = 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  always @(posedge clk)
    rd_d <= rd;

  always @(negedge clk)
    if (rd_d === 1'b1 && exp_q.size() > 0)
      cmp_rd({hit, rdata}, exp_q.pop_front());

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    {wr, rd, st_det, sp_det, ta_clk, ecyc, nrst} = '0;
    cmpr = '0;
    addr = '0;
    wdata = '0;
    eaddr = '0;
    emode = '0;
    pin_in = '0;
    void'($urandom(32'hCED4));
    repeat (20) @(negedge clk);
    cmp_lv(64'(xram_en), 64'h1);
    cmp_lv(oe_n, '1);
    nrst = 1'b1;
    for (int p = 0; p < 5; p++)
    begin
      wr_reg(ADDR_PAGE_IDX, 8'(p));
      rd_reg(ADDR_PAGED_A4, 9'h100);
    end
    v = 8'($urandom);
    wr_reg(ADDR_ROUTE_ONE, v);
    rd_reg(ADDR_ROUTE_ONE, {1'b1, v});
    settle();
    cmp_lv(64'(psel), 64'(v[0]));
    cmp_lv(64'(xram_en), 64'(!v[1]));
    cmp_lv(64'({route.spi_route_sel, route.timer01_route_sel}),
           64'({v[5], v[2]}));
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(ADDR_ROUTE_ONE, {2'(k), 6'h00});
      pin_in = {$urandom, $urandom};
      settle();
      case (k)
        0: e = pin_in[0];
        1: e = pin_in[2];
        2: e = pin_in[5];
        default: e = {pin_in[4][3:0], pin_in[3][7:4]};
      endcase
      cmp_lv(64'(kpd), 64'(e));
    end
    wr_reg(ADDR_TIMER_BUS, 8'hFF);
    rd_reg(ADDR_TIMER_BUS, 9'h1CF);
    ta_clk = 1'b1;
    settle();
    cmp_lv(64'(ta_tick), 64'h1);
    cmp_lv(64'({oe_n[3][5:4], drv[3][4]}), 64'h1);
    ecyc = 1'b1;
    emode = MODE_ADDR_OUT;
    eaddr = 16'($urandom);
    settle();
    cmp_lv(64'({drv[5], drv[6][7:2], drv[7][1:0]}),
           64'({eaddr[7:0], eaddr[15:10], eaddr[9:8]}));
    cmp_lv(64'({oe_n[4][6], drv[4][6]}), 64'h1);
    emode = 2'b10;
    settle();
    cmp_lv(64'(oe_n[5]), 64'hFF);
    ecyc = 1'b0;
    wr_reg(ADDR_TIMER_BUS, 8'h00);
    settle();
    cmp_lv(64'(oe_n[3][5:4]), 64'h3);
    n = 0;
    repeat (120)
    begin
      @(negedge clk);
      n += int'(ta_tick) + int'(tb_tick);
    end
    cmp_lv(64'(n), 64'd20);
    wr_reg(ADDR_PAGE_IDX, {4'h0, PAGE_0});
    st_det = 1'b1;
    sp_det = 1'b1;
    @(negedge clk);
    st_det = 1'b0;
    sp_det = 1'b0;
    wr_reg(ADDR_PAGED_A4, 8'hC0);
    rd_reg(ADDR_PAGED_A4, 9'h1C0);
    cmp_lv(64'({sflag, pflag}), 64'h3);
    wr_reg(ADDR_PAGED_A4, 8'h00);
    rd_reg(ADDR_PAGED_A4, 9'h100);
    st_det = 1'b1;
    wr_reg(ADDR_PAGED_A4, 8'h00);
    st_det = 1'b0;
    rd_reg(ADDR_PAGED_A4, 9'h180);
    for (int k = 0; k < 8; k++)
    begin
      wr_reg(ADDR_PAGE_IDX, {4'h0, PAGE_0});
      wr_reg(ADDR_PAGED_C1, {2'b00, 2'(k), 4'h0});
      wr_reg(ADDR_PAGE_IDX, {4'h0, PAGE_4});
      wr_reg(ADDR_PAGED_A4, (k > 3) ? 8'h04 : 8'h00);
      pin_in = {$urandom, $urandom};
      settle();
      j = IRQ_PIN[0][k % 4];
      e = {7'h00, pin_in[j[5:3]][j[2:0]] ^ (k < 4)};
      cmp_lv(64'(irq[0]), 64'(e));
      cmp_lv(64'(irq[3:2]), 64'({~pin_in[4][2], ~pin_in[4][3]}));
    end
    v = 8'($urandom) & 8'h3F;
    wr_reg(ADDR_PAGE_IDX, {4'h0, PAGE_0});
    wr_reg(ADDR_PAGED_A4, v);
    wr_reg(ADDR_PAGE_IDX, {4'h0, PAGE_3});
    wr_reg(ADDR_PAGED_A4, 8'h01);
    wr_reg(ADDR_PAGE_IDX, {4'h0, PAGE_1});
    wr_reg(ADDR_PAGED_A4, 8'h5A);
    cmpr = 3'($urandom);
    settle();
    cmp_lv(64'({route.two_wire_route_sel, route.timer_c_route_sel}),
           64'(v[2:0]));
    cmp_lv(64'(oe_n[4][4]), 64'(v[5:4] == 2'b00));
    cmp_lv(64'(route.uart_b_route), 64'h4);
    cmp_lv(64'({oe_n[7][2], oe_n[0][0], drv[7][2], drv[0][0]}),
           64'(cmpr[1:0]));
    cmp_lv(64'(ach[1:0]), 64'({cmpr[1], cmpr[0]}));
    wr_reg(ADDR_PAGE_IDX, {4'h0, PAGE_2});
    v = 8'($urandom);
    wr_reg(ADDR_PAGED_A4, v);
    settle();
    cmp_lv(64'({route.serial_aux_in_route, route.uart_d_route_sel,
                route.uart_c_route_sel}), 64'(v[7:5]));
    cmp_lv(64'({route.timer_e_route_sel, route.timer_d_route_sel}),
           64'(v[2:0]));
    wr_reg(ADDR_PAGE_IDX, 8'h0F);
    rd_reg(ADDR_PAGE_IDX, 9'h10F);
    rd_reg(ADDR_PAGED_A4, 9'h000);
    settle();
    cmp_lv(64'(pidx), 64'hF);
    test_done();
  end
endmodule
